// [hw/nrs_dev.sv]
// Device end: serial register slave, shadowed oscillator settings, sync and accumulators
// Assumes the host keeps the frame format and clock limit; sclk may stop between frames
// Operation
// - Frequency word 48 bits, three register writes
// - Phase offset is one 16-bit field
// - Write frame: 8 instruction, 16 data bits
// - Host keeps serial clock at most 10 MHz
// - Host rewrites page select before other channel
// - Host writes frequency, phase if needed
// - Phase write goes with frequency before sync
// - Sync applies pending frequency, others keep theirs
// - Synchronized output about 160 ns after sync
// - Register sync asynchronous; shared pulse preferred
// - Writing sync request bit makes sync pulse
// - Sync input sampled on device clock
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "nrs_map.svh"
module nrs_dev
    import nrs_pkg::*;
#(
    parameter int NCH = 2
) (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    // Link
    nrs_link_if.dev                         link,
    // Oscillator outputs
    output logic [NCH-1:0][`NRS_PHASE_W-1:0] nco_phase_out,
    output logic [NCH-1:0]                  pending_out,
    output logic                            sync_pulse_out
);
    import nrs_pkg::*;

    localparam int FB = `NRS_FRAME_BITS;
    localparam int CW = $clog2(FB);
    localparam logic [3:0] LAT = 4'(`NRS_SYNC_LAT_CYC);

    // Link-side state, clocked by the serial clock
    typedef struct packed {
        logic [FB-2:0] sh;
        logic [CW-1:0] cnt;
        logic [FB-1:0] word;
        logic          tgl;
    } nrs_lnk_t;

    // Core state, clocked by the sample clock
    typedef struct packed {
        logic [2:0]                   tg;
        logic [2:0]                   sr;
        nrs_word_t                    page;
        logic                         src_sysref;
        logic [NCH-1:0][`NRS_FREQ_W-1:0]  fsh;
        logic [NCH-1:0][`NRS_PHASE_W-1:0] psh;
        logic [NCH-1:0]               pend;
        logic [NCH-1:0][`NRS_FREQ_W-1:0]  finc;
        logic [NCH-1:0][`NRS_PHASE_W-1:0] poff;
        logic [NCH-1:0][`NRS_FREQ_W-1:0]  acc;
        logic [NCH-1:0][`NRS_PHASE_W-1:0] ph;
        logic [3:0]                   dly;
        logic                         pulse;
    } nrs_core_t;

    nrs_lnk_t  l_q;
    nrs_lnk_t  l_d;
    nrs_core_t q;
    nrs_core_t d;

    // Writes one 16-bit slice of a 48-bit frequency word
    function automatic nrs_freq_t nrs_put16(nrs_freq_t old, int sl, nrs_word_t v);
        nrs_freq_t r;
        r = old;
        r[sl*`NRS_REG_W +: `NRS_REG_W] = v;
        return r;
    endfunction

    // Serial shifter: sample on rising edge, 24 bits per frame
    always_comb begin
        l_d = l_q;
        if (!link.cs_n) begin
            if (l_q.cnt == CW'(FB - 1)) begin
                l_d.word = {l_q.sh, link.mosi};
                l_d.tgl  = ~l_q.tgl;
                l_d.cnt  = '0;
            end else begin
                l_d.sh  = {l_q.sh[FB-3:0], link.mosi};
                l_d.cnt = l_q.cnt + CW'(1);
            end
        end
    end

    // Word stays stable for a whole frame, far longer than the toggle sync
    always_ff @(posedge link.sclk or negedge rst_n_in) begin
        if (!rst_n_in) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    logic                   wr_ev;
    logic [6:0]             wr_addr;
    nrs_word_t              wr_data;
    logic                   sel_ok;
    logic                   sync_ev;
    int                     pg;

    always_comb begin
        d       = q;
        d.tg    = {q.tg[1:0], l_q.tgl};
        d.sr    = {q.sr[1:0], link.sysref};
        d.pulse = 1'b0;
        wr_ev   = (q.tg[2] != q.tg[1]) && !l_q.word[FB-1-(`NRS_INSTR_W-1-`NRS_RD_BIT)];
        wr_addr = l_q.word[FB-2:`NRS_REG_W];
        wr_data = l_q.word[`NRS_REG_W-1:0];
        sel_ok  = q.page < NCH;
        pg      = sel_ok ? int'(q.page) : 0;
        sync_ev = 1'b0;

        for (int i = 0; i < NCH; i++) begin
            d.acc[i] = q.acc[i] + q.finc[i];
            d.ph[i]  = q.acc[i][`NRS_FREQ_W-1 -: `NRS_PHASE_W] + q.poff[i];
        end

        // Shared sync pulse only when selected as source
        if (q.src_sysref && q.sr[1] && !q.sr[2]) begin
            sync_ev = 1'b1;
        end

        if (q.dly != 4'h0) begin
            d.dly = q.dly - 4'h1;
            if (q.dly == 4'h1) begin
                d.pulse = 1'b1;
                for (int i = 0; i < NCH; i++) begin
                    d.acc[i] = '0;
                    if (q.pend[i]) begin
                        d.finc[i] = q.fsh[i];
                        d.poff[i] = q.psh[i];
                        d.pend[i] = 1'b0;
                    end
                end
            end
        end

        // Frequency and phase writes land in shadow storage; a new write beats a same-cycle clear
        if (wr_ev) begin
            case (wr_addr)
                `NRS_A_FREQ0, `NRS_A_FREQ1, `NRS_A_FREQ2: begin
                    if (sel_ok) begin
                        d.fsh[pg]  = nrs_put16(q.fsh[pg], int'(wr_addr), wr_data);
                        d.pend[pg] = 1'b1;
                    end
                end
                `NRS_A_PHASE: begin
                    if (sel_ok) begin
                        d.psh[pg]  = wr_data;
                        d.pend[pg] = 1'b1;
                    end
                end
                `NRS_A_PAGE: begin
                    d.page = wr_data;
                end
                `NRS_A_SYNC: begin
                    d.src_sysref = wr_data[`NRS_SYNC_SRC_BIT];
                    if (wr_data[`NRS_SYNC_REQ_BIT]) begin
                        sync_ev = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // A sync arriving while one is in flight restarts the wait
        if (sync_ev) begin
            d.dly = LAT;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q            <= '0;
            q.src_sysref <= `NRS_SYNC_SRC_RST;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        nco_phase_out  = q.ph;
        pending_out    = q.pend;
        sync_pulse_out = q.pulse;
    end
endmodule

// [hw/nrs_host.sv]
// Host end: sends 24-bit register write frames and issues the shared sync pulse
// Software reaches it over a plain port with read data one cycle after the strobe
`timescale 1ns/10ps
`include "nrs_map.svh"
module nrs_host
    import nrs_pkg::*;
#(
    parameter int SCLK_HALF = `NRS_SCLK_HALF
) (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // Software port
    input  wire logic [3:0]           addr_in,
    input  wire nrs_pkg::nrs_word_t   wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output nrs_pkg::nrs_word_t        rdata_out,
    output logic                      busy_out,
    // Link
    nrs_link_if.host                  link
);
    import nrs_pkg::*;

    localparam int FB = `NRS_FRAME_BITS;
    localparam int CW = $clog2(FB + 1);
    localparam int HW = $clog2(SCLK_HALF + 1);

    typedef struct packed {
        nrs_host_st_t            st;
        logic [`NRS_INSTR_W-1:0] instr;
        logic [FB-1:0]           sh;
        logic [CW-1:0]           cnt;
        logic [HW-1:0]           half;
        logic                    sclk;
        logic                    cs_n;
        logic [1:0]              srcnt;
        logic                    sysref;
        nrs_word_t               rdata;
    } nrs_hst_t;

    nrs_hst_t q;
    nrs_hst_t d;

    always_comb begin
        d       = q;
        d.rdata = '0;
        if (rd_in) begin
            case (addr_in)
                `NRS_H_INSTR: d.rdata = {{(`NRS_REG_W-`NRS_INSTR_W){1'b0}}, q.instr};
                `NRS_H_STAT:  d.rdata = {{(`NRS_REG_W-1){1'b0}}, q.st != NRS_IDLE};
                default:      d.rdata = '0;
            endcase
        end

        if (q.srcnt != 2'h0) begin
            d.srcnt = q.srcnt - 2'h1;
        end

        case (q.st)
            NRS_SHIFT: begin
                // Divided clock keeps the serial rate at or below its ceiling
                if (q.half == '0) begin
                    d.half = HW'(SCLK_HALF - 1);
                    if (!q.sclk) begin
                        d.sclk = 1'b1;
                    end else begin
                        d.sclk = 1'b0;
                        d.sh   = {q.sh[FB-2:0], 1'b0};
                        d.cnt  = q.cnt - CW'(1);
                        if (q.cnt == CW'(1)) begin
                            d.st = NRS_DONE;
                        end
                    end
                end else begin
                    d.half = q.half - HW'(1);
                end
            end
            NRS_DONE: begin
                d.cs_n = 1'b1;
                d.st   = NRS_IDLE;
            end
            default: begin
                d.st = NRS_IDLE;
            end
        endcase

        if (wr_in) begin
            case (addr_in)
                `NRS_H_INSTR: d.instr = wdata_in[`NRS_INSTR_W-1:0];
                `NRS_H_DATA: begin
                    // A launch while a frame is running is dropped
                    if (q.st == NRS_IDLE) begin
                        d.sh   = {q.instr, wdata_in};
                        d.cnt  = CW'(FB);
                        d.half = HW'(SCLK_HALF - 1);
                        d.cs_n = 1'b0;
                        d.st   = NRS_SHIFT;
                    end
                end
                `NRS_H_SYSREF: d.srcnt = 2'(`NRS_SYSREF_CYC);
                default: begin
                end
            endcase
        end
        d.sysref = d.srcnt != 2'h0;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q      <= '0;
            q.st   <= NRS_IDLE;
            q.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        rdata_out   = q.rdata;
        busy_out    = q.st != NRS_IDLE;
        link.sclk   = q.sclk;
        link.cs_n   = q.cs_n;
        link.mosi   = q.sh[FB-1];
        link.sysref = q.sysref;
    end
endmodule

// [hw/nrs_link_if.sv]
// Serial register link plus the shared sync pulse between host and device
// The host makes the serial clock; the device clocks its serial logic on it
`timescale 1ns/10ps
interface nrs_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic sysref;
    modport dev  (input sclk, input cs_n, input mosi, input sysref);
    modport host (output sclk, output cs_n, output mosi, output sysref);
endinterface

// [hw/nrs_map.svh]
// Numeric map of the oscillator retune link: widths, register addresses, timing
// Included by the package and by both ends; definitions only
`ifndef NRS_MAP_SVH
`define NRS_MAP_SVH
`define NRS_FREQ_W       48
`define NRS_PHASE_W      16
`define NRS_REG_W        16
`define NRS_INSTR_W      8
`define NRS_FRAME_BITS   24
`define NRS_RD_BIT       7
// Device registers, 7-bit address in the instruction byte
`define NRS_A_FREQ0      7'h00
`define NRS_A_FREQ1      7'h01
`define NRS_A_FREQ2      7'h02
`define NRS_A_PHASE      7'h03
`define NRS_A_PAGE       7'h04
`define NRS_A_SYNC       7'h05
`define NRS_SYNC_REQ_BIT 0
`define NRS_SYNC_SRC_BIT 1
`define NRS_SYNC_SRC_RST 1'b1
// Host registers on the plain software port
`define NRS_H_INSTR      4'h0
`define NRS_H_DATA       4'h1
`define NRS_H_STAT       4'h2
`define NRS_H_SYSREF     4'h3
`define NRS_SYSREF_CYC   2
// Timing
`define NRS_CLK_HZ       20000000
`define NRS_CLK_NS       50
`define NRS_SCLK_MAX_HZ  10000000
`define NRS_SCLK_HALF    ((`NRS_CLK_HZ + 2 * `NRS_SCLK_MAX_HZ - 1) / (2 * `NRS_SCLK_MAX_HZ))
`define NRS_SYNC_LAT_NS  160
`define NRS_SYNC_LAT_CYC (`NRS_SYNC_LAT_NS / `NRS_CLK_NS)
`endif

// [hw/nrs_pkg.sv]
// Shared types of the oscillator retune link
// Assumes nrs_map.svh is on the include path
`include "nrs_map.svh"
package nrs_pkg;
    typedef logic [`NRS_REG_W-1:0]   nrs_word_t;
    typedef logic [`NRS_PHASE_W-1:0] nrs_phase_t;
    typedef logic [`NRS_FREQ_W-1:0]  nrs_freq_t;
    typedef enum logic [1:0] {
        NRS_IDLE  = 2'h0,
        NRS_SHIFT = 2'h1,
        NRS_DONE  = 2'h3
    } nrs_host_st_t;
endpackage

// [testbench/nrs_link_asserts.sv]
// Link checker: frame shape, serial clock rate and sync pulse width
// Takes the link signals as plain inputs, sampled on the host clock
`timescale 1ns/10ps
module nrs_link_chk (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Link
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic sysref_in
);
    logic [4:0] nbits_q;
    logic       sclk_q;
    // Serial rises are counted here because sclk is itself a host flop
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nbits_q <= 5'h00;
            sclk_q  <= 1'b0;
        end else begin
            sclk_q  <= sclk_in;
            nbits_q <= cs_n_in ? 5'h00 : nbits_q + {4'h0, sclk_in & !sclk_q};
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_SCLK_IDLE: assert property (cs_n_in |-> !sclk_in) else $error("sclk moves outside frame");
    AST_FRAME_BITS: assert property ($rose(cs_n_in) |-> nbits_q == 5'h18) else $error("bad bit count");
    AST_MOSI_HOLD: assert property (sclk_in |-> $stable(mosi_in)) else $error("mosi moved, sclk high");
    AST_SCLK_RATE: assert property (sclk_in |=> !sclk_in) else $error("sclk high too long");
    AST_SYSREF_W: assert property ($rose(sysref_in) |-> sysref_in [*2] ##1 !sysref_in) else $error("sysref width");
    AST_CS_START: assert property ($fell(cs_n_in) |-> !sclk_in ##1 sclk_in) else $error("frame start");
    AST_FRAME_LEN: assert property ($fell(cs_n_in) |-> ##49 $rose(cs_n_in)) else $error("frame length");
    AST_CS_GAP: assert property ($rose(cs_n_in) |=> cs_n_in [*2]) else $error("frame gap too short");
endmodule

// [testbench/tb_top.sv]
// Bench: host and device ends joined by the link, driven over the software port
// Assumes the design files and the link checker are compiled first
`timescale 1ns/10ps
`include "nrs_map.svh"
module tb_top;
    import nrs_pkg::*;
    logic             clk_in = 1'b0;
    logic             rst_n_in = 1'b1;
    logic [3:0]       addr_in = 4'h0;
    nrs_word_t        wdata_in = 16'h0000;
    logic             wr_in = 1'b0;
    logic             rd_in = 1'b0;
    nrs_word_t        rdata_out;
    logic             busy_out;
    logic [1:0][15:0] nco_phase_out;
    logic [1:0]       pending_out;
    logic             sync_pulse_out;
    logic [23:0]      cap_q = 24'h000000;
    int               fail_count = 0;
    int               n_tests = 0;
    int               n = 0;
    nrs_link_if link ();
    nrs_host u_nrs_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .busy_out(busy_out), .link(link));
    nrs_dev #(.NCH(2)) u_nrs_dev (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
        .nco_phase_out(nco_phase_out), .pending_out(pending_out), .sync_pulse_out(sync_pulse_out));
    nrs_link_chk u_nrs_link_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(link.sclk), .cs_n_in(link.cs_n),
        .mosi_in(link.mosi), .sysref_in(link.sysref));
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    // Frame as the device sees it, independent of the host's own shifter
    always @(posedge link.sclk) begin
        if (!link.cs_n) begin
            cap_q <= {cap_q[22:0], link.mosi};
        end
    end
    task automatic conclude();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic sw_wr(input logic [3:0] a, input nrs_word_t d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic sw_rd(input logic [3:0] a, input nrs_word_t exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk("rdata", {32'h0, rdata_out}, {32'h0, exp});
    endtask
    task automatic frame(input logic [6:0] a, input nrs_word_t d);
        sw_wr(`NRS_H_INSTR, {8'h00, 1'b0, a});
        sw_wr(`NRS_H_DATA, d);
    endtask
    task automatic dev_wr(input logic [6:0] a, input nrs_word_t d);
        frame(a, d);
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (busy_out !== 1'b0 && n < 100);
        chk("busy", {47'h0, busy_out}, 48'h0);
        // The device applies a write a few cycles after the last serial edge
        repeat (5) @(posedge clk_in);
        #1;
        chk("frame", {24'h0, cap_q}, {24'h0, 1'b0, a, d});
    endtask
    task automatic sync_chk(input nrs_word_t e0, input nrs_word_t e1);
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (sync_pulse_out !== 1'b1 && n < 80);
        chk("sync", {47'h0, sync_pulse_out}, 48'h1);
        chk("pending", {46'h0, pending_out}, 48'h0);
        repeat (5) @(posedge clk_in);
        #1;
        chk("nco0", {32'h0, nco_phase_out[0]}, {32'h0, e0});
        chk("nco1", {32'h0, nco_phase_out[1]}, {32'h0, e1});
    endtask
    initial begin
        // An explicit falling edge, so the serial-clock flops reset before sclk ever moves
        rst_n_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        dev_wr(`NRS_A_PAGE, 16'h0000);
        dev_wr(`NRS_A_FREQ0, 16'h0000);
        dev_wr(`NRS_A_FREQ1, 16'h0000);
        dev_wr(`NRS_A_FREQ2, 16'h0001);
        dev_wr(`NRS_A_PHASE, 16'h0100);
        dev_wr(`NRS_A_PAGE, 16'h0001);
        dev_wr(`NRS_A_FREQ2, 16'h0003);
        chk("pending", {46'h0, pending_out}, 48'h3);
        chk("nco0", {32'h0, nco_phase_out[0]}, 48'h0);
        sw_rd(`NRS_H_STAT, 16'h0000);
        sw_rd(4'hf, 16'h0000);
        sw_wr(`NRS_H_SYSREF, 16'h0000);
        sync_chk(16'h0104, 16'h000c);
        chk("latency", 48'(n >= 3 && n <= 10), 48'h1);
        // Page beyond the last channel must not reach any shadow word
        dev_wr(`NRS_A_PAGE, 16'h0002);
        dev_wr(`NRS_A_FREQ2, 16'h0009);
        chk("pending", {46'h0, pending_out}, 48'h0);
        dev_wr(`NRS_A_PAGE, 16'h0001);
        dev_wr(`NRS_A_FREQ2, 16'h0005);
        chk("pending", {46'h0, pending_out}, 48'h2);
        frame(`NRS_A_SYNC, 16'h0003);
        sync_chk(16'h0104, 16'h0014);
        // Register source selected: the shared pulse must not apply anything
        dev_wr(`NRS_A_SYNC, 16'h0000);
        sw_rd(`NRS_H_INSTR, 16'h0005);
        dev_wr(`NRS_A_FREQ0, 16'h0001);
        sw_wr(`NRS_H_SYSREF, 16'h0000);
        repeat (12) @(posedge clk_in);
        #1;
        chk("pending", {46'h0, pending_out}, 48'h2);
        // A launch while a frame runs is dropped
        frame(`NRS_A_FREQ1, 16'h0002);
        sw_rd(`NRS_H_STAT, 16'h0001);
        sw_wr(`NRS_H_DATA, 16'h0007);
        repeat (60) @(posedge clk_in);
        #1;
        chk("frame", {24'h0, cap_q}, {24'h0, 8'h01, 16'h0002});
        chk("busy", {47'h0, busy_out}, 48'h0);
        conclude();
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        fail_count++;
        conclude();
    end
endmodule
